// ---- core/swr_pkg.sv ----
package swr_pkg;

	// ------------------------------------------------------------
	// clock and line timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int T_RST_STD_US = 480;
	localparam int T_RST_OD_US = 48;
	localparam int T_OD_KEEP_US = 80;
	localparam int T_SAMPLE_STD_US = 30;
	localparam int T_SAMPLE_OD_US = 3;
	localparam int T_PDH_STD_US = 30;
	localparam int T_PDH_OD_US = 3;
	localparam int T_PDL_STD_US = 120;
	localparam int T_PDL_OD_US = 12;
	localparam int RST_STD_CYC_DEF = T_RST_STD_US * CLK_MHZ;
	localparam logic [15:0] RST_OD_CYC = 16'(T_RST_OD_US * CLK_MHZ);
	localparam logic [15:0] OD_KEEP_CYC = 16'(T_OD_KEEP_US * CLK_MHZ);
	localparam logic [15:0] SAMPLE_STD_CYC = 16'(T_SAMPLE_STD_US * CLK_MHZ);
	localparam logic [15:0] SAMPLE_OD_CYC = 16'(T_SAMPLE_OD_US * CLK_MHZ);
	localparam logic [15:0] PDH_STD_CYC = 16'(T_PDH_STD_US * CLK_MHZ);
	localparam logic [15:0] PDH_OD_CYC = 16'(T_PDH_OD_US * CLK_MHZ);
	localparam logic [15:0] PDL_STD_CYC = 16'(T_PDL_STD_US * CLK_MHZ);
	localparam logic [15:0] PDL_OD_CYC = 16'(T_PDL_OD_US * CLK_MHZ);

	// ------------------------------------------------------------
	// identifier layout and check
	// ------------------------------------------------------------
	localparam int ID_BITS = 64;
	localparam int ID_DATA_BITS = 56;
	localparam logic [7:0] CRC_POLY_REV = 8'h8c;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// ------------------------------------------------------------
	// command codes and states
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ID = 8'h33;
	localparam logic [7:0] CMD_MATCH = 8'h55;
	localparam logic [7:0] CMD_SEARCH = 8'hf0;
	localparam logic [7:0] CMD_SKIP = 8'hcc;
	localparam logic [7:0] CMD_RESUME = 8'ha5;
	localparam logic [7:0] CMD_OD_SKIP = 8'h3c;
	localparam logic [7:0] CMD_OD_MATCH = 8'h69;

	typedef enum logic [7:0] {
		ST_WAIT = 8'h01,
		ST_PWAIT = 8'h02,
		ST_PLOW = 8'h04,
		ST_CMD = 8'h08,
		ST_READ = 8'h10,
		ST_MATCH = 8'h20,
		ST_SEARCH = 8'h40,
		ST_DEV = 8'h80
	} swr_state_t;

	// serial check over the 56 data bits, lsb first
	function automatic logic [7:0] swr_crc56(input logic [55:0] data);
		logic [7:0] crc;
		logic fb;
		crc = CRC_INIT;
		for (int i = 0; i < ID_DATA_BITS; i++) begin
			fb = crc[0] ^ data[i];
			crc = (crc >> 1) ^ (fb ? CRC_POLY_REV : 8'h00);
		end
		return crc;
	endfunction

endpackage

// ---- core/swr_crc_if.sv ----
`timescale 1ns/1ps
interface swr_crc_if;
	logic clr;
	logic shiftEn;
	logic dataBit;
	logic [7:0] crc;
	modport user(output clr, output shiftEn, output dataBit, input crc);
	modport engine(input clr, input shiftEn, input dataBit, output crc);
endinterface

// ---- core/swr_crc8.sv ----
`timescale 1ns/1ps
module swr_crc8
	import swr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	swr_crc_if.engine crcIf
);

	logic [7:0] crc_ff;
	logic fb;

	// feedback tap of the reversed shift register
	assign fb = crc_ff[0] ^ crcIf.dataBit;

	always_ff @(posedge clk_sys) begin
		if (sys_rst || crcIf.clr) begin
			crc_ff <= CRC_INIT;
		end else if (crcIf.shiftEn) begin
			crc_ff <= (crc_ff >> 1) ^ (fb ? CRC_POLY_REV : 8'h00);
		end
	end

	assign crcIf.crc = crc_ff;

endmodule

// ---- core/swr_rom_layer.sv ----
`timescale 1ns/1ps
// Contract
// - command is one byte after initialisation
// - every bit moves lsb first
// - overdrive command byte switches to fast timing
// - identifier is family, serial, check byte
// - check uses x8+x5+x4+1 shift register
// - check register starts at zero
// - shifting check byte in leaves zero
// - line only pulled low, never driven high
// - standard and overdrive bit rates
// - reset pulse answered by presence pulse
// - read command sends whole identifier
// - match command compares 64 received bits
// - unmatched device ignores line until reset
// - search bit uses true, complement, select
// - search mismatch drops out until reset
// - skip goes straight to device commands
// - resume proceeds only with resume flag
// - resume flag set on successful addressing
// - resume flag cleared when another selected
// - overdrive skip sets overdrive, skips identifier
// - long reset clears overdrive flag
// - overdrive match sets overdrive at the command byte, match or not
// - short overdrive reset keeps overdrive flag
module swr_rom_layer
	import swr_pkg::*;
#(
	parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
	parameter logic [47:0] SERIAL_NUM = 48'h0123_4567_89ab, // arbitrary value
	parameter int RST_STD_CYC = RST_STD_CYC_DEF
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic lineIn,
	output logic lineOut,
	output logic lineOe,
	output logic romDone,
	output logic devActive,
	output logic devBitValid,
	output logic devBit,
	input wire logic devTxEn,
	input wire logic devTxBit,
	output logic overdriveFlag,
	output logic resumeFlag,
	output logic idCrcOk
);

	// ------------------------------------------------------------
	// identifier
	// ------------------------------------------------------------
	// family low, serial, check byte on top
	localparam logic [55:0] ID_DATA = {SERIAL_NUM, FAMILY_CODE};
	localparam logic [63:0] OWN_ID = {swr_crc56(ID_DATA), ID_DATA};
	localparam logic [15:0] RST_STD_LIM = 16'(RST_STD_CYC);

	swr_state_t st_ff;
	logic lineMeta_ff, lineSync_ff, linePrev_ff;
	logic [15:0] lowCnt_ff, slotCnt_ff, presCnt_ff;
	logic slotBusy_ff, driveZero_ff;
	logic [5:0] bitCnt_ff;
	logic [1:0] phase_ff;
	logic [7:0] cmdSr_ff;
	logic mism_ff, od_ff, resume_ff, romDone_ff, crcChk_ff, idCrcOk_ff;
	logic devBitValid_ff, devBit_ff;
	logic fallDet, riseDet, presSt, slotSt, rstDet, longRst;
	logic slotStart, sampleStb, last64, idBit, rxBit;
	logic txNeed, txBit, cmdDone, readDone, matchDone, matchOk;
	logic searchDrop, searchDone;
	logic [7:0] cmdByte;
	logic [15:0] sampleCyc, pdhCyc, pdlCyc;

	swr_crc_if crcIf();

	swr_crc8 u_crc (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.crcIf(crcIf.engine)
	);

	// ------------------------------------------------------------
	// line input synchroniser and edges
	// ------------------------------------------------------------
	// two stages before any logic sees the pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lineMeta_ff <= 1'b1;
			lineSync_ff <= 1'b1;
			linePrev_ff <= 1'b1;
		end else begin
			lineMeta_ff <= lineIn;
			lineSync_ff <= lineMeta_ff;
			linePrev_ff <= lineSync_ff;
		end
	end

	// edge and phase helpers
	assign fallDet = linePrev_ff && !lineSync_ff;
	assign riseDet = !linePrev_ff && lineSync_ff;
	assign rxBit = lineSync_ff;
	assign presSt = (st_ff == ST_PWAIT) || (st_ff == ST_PLOW);
	assign slotSt = (st_ff == ST_CMD) || (st_ff == ST_READ) || (st_ff == ST_MATCH) ||
		(st_ff == ST_SEARCH) || (st_ff == ST_DEV);

	assign sampleCyc = od_ff ? SAMPLE_OD_CYC : SAMPLE_STD_CYC;
	assign pdhCyc = od_ff ? PDH_OD_CYC : PDH_STD_CYC;
	assign pdlCyc = od_ff ? PDL_OD_CYC : PDL_STD_CYC;

	// ------------------------------------------------------------
	// reset pulse measurement
	// ------------------------------------------------------------
	// low time of the line, saturating
	always_ff @(posedge clk_sys) begin
		if (sys_rst || lineSync_ff) begin
			lowCnt_ff <= 16'h0000;
		end else if (lowCnt_ff != 16'hffff) begin
			lowCnt_ff <= lowCnt_ff + 16'h0001;
		end
	end

	// reset seen at release of a long low
	assign rstDet = riseDet && !presSt && (lowCnt_ff >= (od_ff ? RST_OD_CYC : RST_STD_LIM));
	// only a long low clears overdrive
	assign longRst = riseDet && !presSt && (lowCnt_ff >= RST_STD_LIM);

	// ------------------------------------------------------------
	// time slot engine
	// ------------------------------------------------------------
	assign slotStart = fallDet && slotSt && !slotBusy_ff;
	assign sampleStb = slotBusy_ff && (slotCnt_ff == sampleCyc);

	// slot timer from master falling edge to sample point
	always_ff @(posedge clk_sys) begin
		if (sys_rst || rstDet) begin
			slotBusy_ff <= 1'b0;
			slotCnt_ff <= 16'h0000;
		end else if (slotStart) begin
			slotBusy_ff <= 1'b1;
			slotCnt_ff <= 16'h0001;
		end else if (sampleStb) begin
			slotBusy_ff <= 1'b0;
			slotCnt_ff <= 16'h0000;
		end else if (slotBusy_ff) begin
			slotCnt_ff <= slotCnt_ff + 16'h0001;
		end
	end

	// bit this device sends in the coming slot
	always_comb begin
		txNeed = 1'b0;
		txBit = 1'b1;
		unique case (st_ff)
			ST_READ: begin
				txNeed = 1'b1;
				txBit = idBit;
			end
			ST_SEARCH: begin
				txNeed = (phase_ff != 2'd2);
				txBit = (phase_ff == 2'd0) ? idBit : !idBit;
			end
			ST_DEV: begin
				txNeed = devTxEn;
				txBit = devTxBit;
			end
			default: begin
				txNeed = 1'b0;
				txBit = 1'b1;
			end
		endcase
	end

	// zero bits hold the line low until the sample point
	always_ff @(posedge clk_sys) begin
		if (sys_rst || rstDet || sampleStb) begin
			driveZero_ff <= 1'b0;
		end else if (slotStart && txNeed && !txBit) begin
			driveZero_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// bit bookkeeping
	// ------------------------------------------------------------
	assign last64 = (bitCnt_ff == 6'(ID_BITS - 1));
	assign idBit = OWN_ID[bitCnt_ff];
	assign cmdByte = {rxBit, cmdSr_ff[7:1]};
	assign cmdDone = (st_ff == ST_CMD) && sampleStb && (bitCnt_ff[2:0] == 3'h7);
	assign readDone = (st_ff == ST_READ) && sampleStb && last64;
	assign matchDone = (st_ff == ST_MATCH) && sampleStb && last64;
	assign matchOk = !mism_ff && (rxBit == idBit);
	assign searchDrop = (st_ff == ST_SEARCH) && sampleStb && (phase_ff == 2'd2) &&
		(rxBit != idBit);
	assign searchDone = (st_ff == ST_SEARCH) && sampleStb && (phase_ff == 2'd2) &&
		last64 && !searchDrop;

	// counters, shift register and mismatch tracker
	always_ff @(posedge clk_sys) begin
		if (sys_rst || rstDet || cmdDone) begin
			bitCnt_ff <= 6'h00;
			phase_ff <= 2'd0;
			cmdSr_ff <= 8'h00;
			mism_ff <= 1'b0;
		end else if (sampleStb) begin
			if (st_ff == ST_CMD) begin
				cmdSr_ff <= cmdByte;
				bitCnt_ff <= bitCnt_ff + 6'h01;
			end else if (st_ff == ST_READ || st_ff == ST_MATCH) begin
				bitCnt_ff <= bitCnt_ff + 6'h01;
				if (st_ff == ST_MATCH && rxBit != idBit) begin
					mism_ff <= 1'b1;
				end
			end else if (st_ff == ST_SEARCH) begin
				if (phase_ff == 2'd2) begin
					phase_ff <= 2'd0;
					bitCnt_ff <= bitCnt_ff + 6'h01;
				end else begin
					phase_ff <= phase_ff + 2'd1;
				end
			end
		end
	end

	// presence delay and pulse width timer
	always_ff @(posedge clk_sys) begin
		if (sys_rst || rstDet) begin
			presCnt_ff <= 16'h0000;
		end else if (st_ff == ST_PWAIT && presCnt_ff == pdhCyc) begin
			presCnt_ff <= 16'h0000;
		end else if (presSt) begin
			presCnt_ff <= presCnt_ff + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// rom function state machine
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_ff <= ST_WAIT;
		end else if (rstDet) begin
			st_ff <= ST_PWAIT;
		end else begin
			unique case (st_ff)
				ST_WAIT: begin
					st_ff <= ST_WAIT;
				end
				ST_PWAIT: begin
					if (presCnt_ff == pdhCyc) begin
						st_ff <= ST_PLOW;
					end
				end
				ST_PLOW: begin
					if (presCnt_ff == pdlCyc) begin
						st_ff <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (cmdDone) begin
						unique case (cmdByte)
							CMD_READ_ID: st_ff <= ST_READ;
							CMD_MATCH, CMD_OD_MATCH: st_ff <= ST_MATCH;
							CMD_SEARCH: st_ff <= ST_SEARCH;
							CMD_SKIP, CMD_OD_SKIP: st_ff <= ST_DEV;
							CMD_RESUME: st_ff <= resume_ff ? ST_DEV : ST_WAIT;
							default: st_ff <= ST_WAIT;
						endcase
					end
				end
				ST_READ: begin
					// after the check byte is out
					if (readDone) begin
						st_ff <= ST_DEV;
					end
				end
				ST_MATCH: begin
					if (matchDone) begin
						st_ff <= matchOk ? ST_DEV : ST_WAIT;
					end
				end
				ST_SEARCH: begin
					if (searchDrop) begin
						st_ff <= ST_WAIT;
					end else if (searchDone) begin
						st_ff <= ST_DEV;
					end
				end
				ST_DEV: begin
					st_ff <= ST_DEV;
				end
				default: begin
					st_ff <= ST_WAIT;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// speed and resume flags
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			od_ff <= 1'b0;
		end else if (longRst) begin
			// long reset returns to standard speed
			od_ff <= 1'b0;
		end else if (cmdDone && (cmdByte == CMD_OD_SKIP || cmdByte == CMD_OD_MATCH)) begin
			// fast timing from the next slot
			od_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			resume_ff <= 1'b0;
		end else if (searchDone || (matchDone && matchOk)) begin
			resume_ff <= 1'b1;
		end else if (searchDrop || (matchDone && !matchOk)) begin
			resume_ff <= 1'b0;
		end else if (cmdDone && (cmdByte == CMD_READ_ID || cmdByte == CMD_SKIP ||
			cmdByte == CMD_OD_SKIP)) begin
			resume_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// received identifier check
	// ------------------------------------------------------------
	// cleared by a bus reset and when each command byte completes
	assign crcIf.clr = rstDet || cmdDone;
	assign crcIf.shiftEn = (st_ff == ST_MATCH) && sampleStb;
	assign crcIf.dataBit = rxBit;

	// residue zero after all 64 bits
	always_ff @(posedge clk_sys) begin
		if (sys_rst || rstDet) begin
			crcChk_ff <= 1'b0;
			idCrcOk_ff <= 1'b0;
		end else begin
			crcChk_ff <= matchDone;
			if (crcChk_ff) begin
				idCrcOk_ff <= (crcIf.crc == 8'h00);
			end
		end
	end

	// ------------------------------------------------------------
	// device command side
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			romDone_ff <= 1'b0;
			devBitValid_ff <= 1'b0;
			devBit_ff <= 1'b0;
		end else begin
			romDone_ff <= (st_ff != ST_DEV) && (readDone || searchDone ||
				(matchDone && matchOk) || (cmdDone && (cmdByte == CMD_SKIP ||
				cmdByte == CMD_OD_SKIP || (cmdByte == CMD_RESUME && resume_ff))));
			devBitValid_ff <= (st_ff == ST_DEV) && sampleStb;
			if ((st_ff == ST_DEV) && sampleStb) begin
				devBit_ff <= rxBit;
			end
		end
	end

	assign lineOut = 1'b0;
	assign lineOe = driveZero_ff || (st_ff == ST_PLOW);
	assign romDone = romDone_ff;
	assign devActive = (st_ff == ST_DEV);
	assign devBitValid = devBitValid_ff;
	assign devBit = devBit_ff;
	assign overdriveFlag = od_ff;
	assign resumeFlag = resume_ff;
	assign idCrcOk = idCrcOk_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_NEVER_HIGH:
	assert property (@(posedge clk_sys) disable iff (sys_rst) lineOe |-> !lineOut)
		else $error("line driven high");

	AST_PRESENCE:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		rstDet |=> (st_ff == ST_PWAIT) ##1 !lineOe)
		else $error("reset not followed by presence wait");

	AST_OD_SET:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmdDone && cmdByte == CMD_OD_SKIP) |=> (od_ff && st_ff == ST_DEV))
		else $error("overdrive skip not taken");

	AST_OD_CLEAR:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		longRst |=> !od_ff)
		else $error("long reset kept overdrive");

	AST_OD_KEEP:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(rstDet && od_ff && lowCnt_ff <= OD_KEEP_CYC) |=> od_ff)
		else $error("short reset left overdrive");

	AST_MATCH_FAIL:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(matchDone && !matchOk) |=> (st_ff == ST_WAIT) && !resume_ff)
		else $error("mismatched device stays active");

	AST_SILENT:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st_ff == ST_WAIT) |-> !lineOe)
		else $error("silent device pulled line");

	AST_RESUME_GATE:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmdDone && cmdByte == CMD_RESUME) |=> (st_ff == ST_DEV) == $past(resume_ff))
		else $error("resume ignored flag");

	AST_UNKNOWN:
	assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmdDone && cmdByte == 8'h00) |=> (st_ff == ST_WAIT) [*2])
		else $error("unknown command not ignored");

endmodule

// ---- dv/swr_master_model.sv ----
`timescale 1ns/1ps
module swr_master_model (
	clk_sys,
	lineLevel,
	masterOe
);
	input wire logic clk_sys;
	input wire logic lineLevel;
	output logic masterOe;

	logic fast = 1'b0;

	initial masterOe = 1'b0;

	// ------------------------------------------------------------
	// slot engine
	// ------------------------------------------------------------
	// line released high between slots
	task automatic slot(input int lowCyc, input int smpCyc, input int slotCyc, output logic got);
		got = 1'b1;
		for (int c = 0; c < slotCyc; c++) begin
			@(posedge clk_sys);
			if (c == smpCyc) begin
				got = lineLevel;
			end
			masterOe <= (c < lowCyc);
		end
	endtask

	task automatic setFast(input logic f);
		fast = f;
	endtask

	task automatic writeBit(input logic b);
		logic d;
		if (fast) begin
			slot(b ? 6 : 80, 89, 90, d);
		end else begin
			slot(b ? 60 : 800, 899, 900, d);
		end
	endtask

	task automatic readBit(output logic b);
		if (fast) begin
			slot(6, 40, 90, b);
		end else begin
			slot(30, 300, 900, b);
		end
	endtask

	task automatic busReset(input int lowCyc, output logic seen);
		if (fast) begin
			slot(lowCyc, lowCyc + 150, lowCyc + 450, seen);
		end else begin
			slot(lowCyc, lowCyc + 1500, lowCyc + 4000, seen);
		end
		seen = !seen;
	endtask

	task automatic writeByte(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			writeBit(v[i]);
		end
	endtask
endmodule

// ---- dv/swr_rom_layer_tb.sv ----
`timescale 1ns/1ps
module swr_rom_layer_tb;
	import swr_pkg::*;

	localparam logic [7:0] FAM = 8'h5a; // arbitrary value
	localparam logic [47:0] SER = 48'h0123_4567_89ab; // arbitrary value
	localparam int STD_RST = 3600;
	localparam int OD_RST = 1500;

	typedef struct packed {
		logic [7:0] cmd;
		logic [1:0] idMode; // 0 none, 1 own id, 2 corrupt id, 3 read id
		logic expDev;
		logic expRes;
	} swr_row_t;

	localparam swr_row_t ROWS [7] = '{
		'{CMD_READ_ID, 2'h3, 1'b1, 1'b0}, '{CMD_MATCH, 2'h1, 1'b1, 1'b1},
		'{CMD_RESUME, 2'h0, 1'b1, 1'b1}, '{CMD_MATCH, 2'h2, 1'b0, 1'b0},
		'{CMD_RESUME, 2'h0, 1'b0, 1'b0}, '{8'h00, 2'h0, 1'b0, 1'b0},
		'{CMD_SKIP, 2'h0, 1'b1, 1'b0}};

	logic clk_sys;
	logic sys_rst;
	logic devTxEn;
	logic devTxBit;
	logic lineOut, lineOe, romDone, devActive, devBitValid, devBit;
	logic overdriveFlag, resumeFlag, idCrcOk, masterOe, b0, b1, lastDevBit;
	logic [63:0] idGood, idGot;
	int miscompares = 0;
	int samplesChecked = 0;
	int doneSeen = 0;
	int doneBefore;
	wire logic lineLevel;

	// wired line with pull-up
	assign lineLevel = !(masterOe | lineOe);

	initial clk_sys = 1'b0;
	always #20 clk_sys = ~clk_sys;

	swr_rom_layer #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .RST_STD_CYC(3500)) swr_rom_layer_inst (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .lineIn(lineLevel), .lineOut(lineOut),
		.lineOe(lineOe), .romDone(romDone), .devActive(devActive),
		.devBitValid(devBitValid), .devBit(devBit), .devTxEn(devTxEn), .devTxBit(devTxBit),
		.overdriveFlag(overdriveFlag), .resumeFlag(resumeFlag), .idCrcOk(idCrcOk));

	swr_master_model swr_master_model_inst (
		.clk_sys(clk_sys), .lineLevel(lineLevel), .masterOe(masterOe));

	// ------------------------------------------------------------
	// compare and report
	// ------------------------------------------------------------
	task automatic checkBit(input logic got, input logic exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic checkId(input logic [63:0] got, input logic [63:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: id got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checked %0d, mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// check byte, reflected x8+x5+x4+1 from zero
	function automatic logic [7:0] crcOf(input logic [55:0] d);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			fb = c[0] ^ d[i];
			c = {fb, c[7:5], c[4] ^ fb, c[3] ^ fb, c[2:1]};
		end
		return c;
	endfunction

	// pulse counters and device-side capture
	always @(posedge clk_sys) begin
		if (romDone === 1'b1) doneSeen <= doneSeen + 1;
		if (devBitValid === 1'b1) lastDevBit <= devBit;
		if (lineOut !== 1'b0) checkBit(lineOut, 1'b0, "line driven high");
	end

	task automatic busRst(input int lowCyc);
		logic seen;
		swr_master_model_inst.busReset(lowCyc, seen);
		checkBit(seen, 1'b1, "presence");
	endtask

	task automatic sendId(input logic [63:0] v);
		for (int i = 0; i < 64; i++) swr_master_model_inst.writeBit(v[i]);
	endtask

	// hang guard
	initial begin
		for (int i = 0; i < 99000; i++) @(posedge clk_sys);
		miscompares++;
		$display("wrong value at %0t: run timed out", $time);
		final_report();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		idGood = {crcOf({SER, FAM}), SER, FAM};
		sys_rst <= 1'b1;
		devTxEn <= 1'b0;
		devTxBit <= 1'b0;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		checkBit(lineOe, 1'b0, "reset oe");
		checkBit(overdriveFlag, 1'b0, "reset od");
		checkBit(resumeFlag, 1'b0, "reset resume");
		busRst(STD_RST);
		swr_master_model_inst.writeByte(CMD_OD_SKIP);
		checkBit(overdriveFlag, 1'b1, "od skip flag");
		checkBit(devActive, 1'b1, "od skip active");
		$display("test od skip done");
		swr_master_model_inst.setFast(1'b1);
		// table of command cases at overdrive speed
		foreach (ROWS[r]) begin
			busRst(OD_RST);
			doneBefore = doneSeen;
			swr_master_model_inst.writeByte(ROWS[r].cmd);
			if (ROWS[r].idMode == 2'h3) begin
				for (int i = 0; i < 64; i++) swr_master_model_inst.readBit(idGot[i]);
				checkId(idGot, idGood);
			end else if (ROWS[r].idMode != 2'h0) begin
				sendId(ROWS[r].idMode == 2'h1 ? idGood : idGood ^ 64'h20);
				repeat (4) @(posedge clk_sys);
				checkBit(idCrcOk, ROWS[r].idMode == 2'h1, "residue");
			end
			repeat (4) @(posedge clk_sys);
			checkBit(devActive, ROWS[r].expDev, "active");
			checkBit(doneSeen - doneBefore == 1, ROWS[r].expDev, "done pulse");
			checkBit(resumeFlag, ROWS[r].expRes, "resume");
			checkBit(overdriveFlag, 1'b1, "od kept");
			if (!ROWS[r].expDev) begin
				swr_master_model_inst.readBit(b0);
				checkBit(b0, 1'b1, "silent");
			end
			$display("test row %0d done", r);
		end
		// device-side slots after skip
		@(posedge clk_sys);
		devTxEn <= 1'b1;
		swr_master_model_inst.readBit(b0);
		checkBit(b0, 1'b0, "device tx zero");
		devTxBit <= 1'b1;
		swr_master_model_inst.readBit(b0);
		checkBit(b0, 1'b1, "device tx one");
		devTxEn <= 1'b0;
		swr_master_model_inst.writeBit(1'b0);
		checkBit(lastDevBit, 1'b0, "device rx zero");
		swr_master_model_inst.writeBit(1'b1);
		checkBit(lastDevBit, 1'b1, "device rx one");
		$display("test device slots done");
		// full search then a search that drops out
		busRst(OD_RST);
		swr_master_model_inst.writeByte(CMD_SEARCH);
		for (int i = 0; i < 64; i++) begin
			swr_master_model_inst.readBit(b0);
			swr_master_model_inst.readBit(b1);
			checkBit(b0, idGood[i], "search true");
			checkBit(b1, !idGood[i], "search comp");
			swr_master_model_inst.writeBit(idGood[i]);
		end
		repeat (4) @(posedge clk_sys);
		checkBit(devActive, 1'b1, "search active");
		checkBit(resumeFlag, 1'b1, "search resume");
		busRst(OD_RST);
		swr_master_model_inst.writeByte(CMD_SEARCH);
		for (int i = 0; i < 3; i++) begin
			swr_master_model_inst.readBit(b0);
			swr_master_model_inst.readBit(b1);
			swr_master_model_inst.writeBit(i == 2 ? !idGood[i] : idGood[i]);
		end
		swr_master_model_inst.readBit(b0);
		swr_master_model_inst.readBit(b1);
		checkBit(b0 & b1, 1'b1, "search dropped");
		checkBit(devActive, 1'b0, "dropped idle");
		$display("test search done");
		// long reset back to standard, then overdrive match
		swr_master_model_inst.setFast(1'b0);
		busRst(STD_RST);
		checkBit(overdriveFlag, 1'b0, "long reset od");
		swr_master_model_inst.writeByte(CMD_OD_MATCH);
		checkBit(overdriveFlag, 1'b1, "od match flag");
		swr_master_model_inst.setFast(1'b1);
		sendId(idGood);
		repeat (4) @(posedge clk_sys);
		checkBit(devActive, 1'b1, "od match active");
		checkBit(resumeFlag, 1'b1, "od match resume");
		$display("test od match done");
		// reset in mid-run, slots ignored until a bus reset
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		checkBit(devActive, 1'b0, "rerst active");
		checkBit(overdriveFlag | resumeFlag, 1'b0, "rerst flags");
		swr_master_model_inst.setFast(1'b0);
		swr_master_model_inst.readBit(b0);
		checkBit(b0, 1'b1, "ignored before reset");
		$display("test mid reset done");
		final_report();
	end
endmodule
